// ### include/gpio_port_regs.svh
// Reset values and pad masks for the general purpose port
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define GPIO_WIDTH 8
`define GPIO_IMPL_MASK 8'hf0
`define GPIO_TWO_WIRE_MASK 8'h50
`define GPIO_LATCH_RESET 8'h00
`define GPIO_DIRECTION_RESET 8'hff
`define GPIO_ANALOG_RESET 8'hff
`define GPIO_PULLUP_RESET 8'h00
`define GPIO_THRESHOLD_RESET 8'hff
`define GPIO_SLEW_RESET 8'hff
`define GPIO_OPEN_DRAIN_RESET 8'h00
`define GPIO_EDGE_RESET 8'h00
`define GPIO_TWO_WIRE_RESET 8'h00

`endif

// ### include/gpio_port_pkg.sv
// Types shared by the general purpose port
package gpio_port_pkg;

  typedef enum logic [3:0] {
    SEL_PIN_LEVEL = 4'h0,
    SEL_OUTPUT_LATCH = 4'h1,
    SEL_DIRECTION = 4'h2,
    SEL_ANALOG = 4'h3,
    SEL_PULLUP = 4'h4,
    SEL_THRESHOLD = 4'h5,
    SEL_SLEW = 4'h6,
    SEL_OPEN_DRAIN = 4'h7,
    SEL_EDGE_RISE = 4'h8,
    SEL_EDGE_FALL = 4'h9,
    SEL_TWO_WIRE_SLEW = 4'ha,
    SEL_TWO_WIRE_PULLUP = 4'hb,
    SEL_TWO_WIRE_LEVEL = 4'hc
  } reg_sel_type;

endpackage : gpio_port_pkg

// ### src/pin_input_sync.sv
// Three-stage input synchroniser with agreement filter
module pin_input_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("pin_input_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync_o <= '0;
    end
    else
    begin
      sync_o <= (stage2 & ~(stage2 ^ stage3)) | (sync_o & (stage2 ^ stage3));
    end
  end

endmodule : pin_input_sync

// ### src/general_purpose_io_port.sv
// General purpose I/O port: latch, direction, pad controls, edge events
//
// Function
// - Second port on larger package implements only pins 4 to 7.
// - Pin level read returns sampled pin state, not the latch.
// - Pin level write merges sampled pins with written bits into latch.
// - Latch holds newest write from either latch or pin level path.
// - Latch read returns stored latch value one clock later.
// - Direction gates the driver in every mode, analog included.
// - Direction 1 disables driver; 0 drives the latch bit.
// - Analog select disables digital input; reads and routed input give 0.
// - Analog select leaves digital output functions untouched.
// - All implemented analog select bits set after reset.
// - Pull-up enable 1 turns weak pull-up on, per pin.
// - Threshold select picks Schmitt or TTL for reads and peripherals.
// - Slew bit 1 limits slew; 0 gives maximum rate, per pin.
// - Open-drain bit 1 sinks only; 0 gives push-pull drive.
// - Each pin raises events on chosen rising or falling edges.
// - Dedicated two-wire pads select own slew and SMBus levels; two-wire pull-up bit is only stored and read back.
// - Enabled two-wire levels feed every peripheral reading the pin.
// - After reset the pin output source is the data latch.
// - Enabled analog output forces the digital driver to high impedance.
// - Priority: configuration, analog out, analog in, port and routed.
// - Threshold 1 selects Schmitt, 0 selects TTL, for reads and edges.
// - Bits without an implemented pin read as zero.
// - Pull-up switched off while pin drives, stored bit unchanged.
`include "gpio_port_regs.svh"
module general_purpose_io_port
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = `GPIO_WIDTH,
  parameter logic [WIDTH-1:0] IMPL_MASK = `GPIO_IMPL_MASK,
  parameter logic [WIDTH-1:0] TWO_WIRE_MASK = `GPIO_TWO_WIRE_MASK
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire reg_sel_type wr_sel_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [WIDTH-1:0] wr_bitmask_i,
  input wire logic [WIDTH-1:0] pad_in_schmitt_i,
  input wire logic [WIDTH-1:0] pad_in_ttl_i,
  input wire logic [WIDTH-1:0] pad_in_smbus_i,
  input wire logic [WIDTH-1:0] config_func_en_i,
  input wire logic [WIDTH-1:0] analog_out_en_i,
  input wire logic [WIDTH-1:0] routed_out_sel_i,
  input wire logic [WIDTH-1:0] routed_out_data_i,
  output logic [WIDTH-1:0] pin_level_o,
  output logic [WIDTH-1:0] output_latch_o,
  output logic [WIDTH-1:0] direction_o,
  output logic [WIDTH-1:0] analog_select_o,
  output logic [WIDTH-1:0] pullup_enable_o,
  output logic [WIDTH-1:0] input_threshold_o,
  output logic [WIDTH-1:0] slew_limit_o,
  output logic [WIDTH-1:0] open_drain_o,
  output logic [WIDTH-1:0] edge_rise_en_o,
  output logic [WIDTH-1:0] edge_fall_en_o,
  output logic [WIDTH-1:0] two_wire_slew_o,
  output logic [WIDTH-1:0] two_wire_pullup_o,
  output logic [WIDTH-1:0] two_wire_level_o,
  output logic [WIDTH-1:0] routed_in_o,
  output logic [WIDTH-1:0] edge_event_o,
  output logic [WIDTH-1:0] pad_out_o,
  output logic [WIDTH-1:0] pad_oe_n_o,
  output logic [WIDTH-1:0] pad_pullup_o,
  output logic [WIDTH-1:0] pad_slew_limit_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration checks

  initial
  begin
    if (WIDTH < 1 || WIDTH > 8)
    begin
      $error("general_purpose_io_port: WIDTH must be 1 to 8");
    end
    if ((TWO_WIRE_MASK & ~IMPL_MASK) != '0)
    begin
      $error("general_purpose_io_port: two-wire pads must be implemented pins");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bitmask write: selected bits take new data, others keep base
  function automatic logic [WIDTH-1:0] merge_bits(
    input logic [WIDTH-1:0] base,
    input logic [WIDTH-1:0] data,
    input logic [WIDTH-1:0] mask
  );
    merge_bits = ((base & ~mask) | (data & mask)) & IMPL_MASK;
  endfunction : merge_bits

  function automatic logic is_write(
    input logic en,
    input reg_sel_type sel,
    input reg_sel_type target
  );
    is_write = en && (sel == target);
  endfunction : is_write

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [WIDTH-1:0] output_latch;
  logic [WIDTH-1:0] direction;
  logic [WIDTH-1:0] analog_select;
  logic [WIDTH-1:0] pullup_enable;
  logic [WIDTH-1:0] input_threshold;
  logic [WIDTH-1:0] slew_limit;
  logic [WIDTH-1:0] open_drain;
  logic [WIDTH-1:0] edge_rise_en;
  logic [WIDTH-1:0] edge_fall_en;
  logic [WIDTH-1:0] two_wire_slew;
  logic [WIDTH-1:0] two_wire_pullup;
  logic [WIDTH-1:0] two_wire_level;
  logic [WIDTH-1:0] pin_value;
  logic [WIDTH-1:0] pin_value_prev;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      output_latch <= `GPIO_LATCH_RESET & IMPL_MASK;
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_PIN_LEVEL))
    begin
      output_latch <= merge_bits(pin_value, wr_data_i, wr_bitmask_i);
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_OUTPUT_LATCH))
    begin
      output_latch <= merge_bits(output_latch, wr_data_i, wr_bitmask_i);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      direction <= `GPIO_DIRECTION_RESET & IMPL_MASK;
      analog_select <= `GPIO_ANALOG_RESET & IMPL_MASK;
      pullup_enable <= `GPIO_PULLUP_RESET & IMPL_MASK;
      input_threshold <= `GPIO_THRESHOLD_RESET & IMPL_MASK;
      slew_limit <= `GPIO_SLEW_RESET & IMPL_MASK;
      open_drain <= `GPIO_OPEN_DRAIN_RESET & IMPL_MASK;
    end
    else if (wr_en_i)
    begin
      case (wr_sel_i)
        SEL_DIRECTION:
        begin
          direction <= merge_bits(direction, wr_data_i, wr_bitmask_i);
        end
        SEL_ANALOG:
        begin
          analog_select <= merge_bits(analog_select, wr_data_i, wr_bitmask_i);
        end
        SEL_PULLUP:
        begin
          pullup_enable <= merge_bits(pullup_enable, wr_data_i, wr_bitmask_i);
        end
        SEL_THRESHOLD:
        begin
          input_threshold <= merge_bits(input_threshold, wr_data_i, wr_bitmask_i);
        end
        SEL_SLEW:
        begin
          slew_limit <= merge_bits(slew_limit, wr_data_i, wr_bitmask_i);
        end
        SEL_OPEN_DRAIN:
        begin
          open_drain <= merge_bits(open_drain, wr_data_i, wr_bitmask_i);
        end
        default:
        begin
          direction <= direction;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      edge_rise_en <= `GPIO_EDGE_RESET & IMPL_MASK;
      edge_fall_en <= `GPIO_EDGE_RESET & IMPL_MASK;
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_EDGE_RISE))
    begin
      edge_rise_en <= merge_bits(edge_rise_en, wr_data_i, wr_bitmask_i);
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_EDGE_FALL))
    begin
      edge_fall_en <= merge_bits(edge_fall_en, wr_data_i, wr_bitmask_i);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      two_wire_slew <= `GPIO_TWO_WIRE_RESET & TWO_WIRE_MASK;
      two_wire_pullup <= `GPIO_TWO_WIRE_RESET & TWO_WIRE_MASK;
      two_wire_level <= `GPIO_TWO_WIRE_RESET & TWO_WIRE_MASK;
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_TWO_WIRE_SLEW))
    begin
      two_wire_slew <= merge_bits(two_wire_slew, wr_data_i, wr_bitmask_i) & TWO_WIRE_MASK;
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_TWO_WIRE_PULLUP))
    begin
      two_wire_pullup <= merge_bits(two_wire_pullup, wr_data_i, wr_bitmask_i) & TWO_WIRE_MASK;
    end
    else if (is_write(wr_en_i, wr_sel_i, SEL_TWO_WIRE_LEVEL))
    begin
      two_wire_level <= merge_bits(two_wire_level, wr_data_i, wr_bitmask_i) & TWO_WIRE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path

  logic [3*WIDTH-1:0] pad_sync;
  logic [WIDTH-1:0] sync_schmitt;
  logic [WIDTH-1:0] sync_ttl;
  logic [WIDTH-1:0] sync_smbus;
  logic [WIDTH-1:0] threshold_pick;

  pin_input_sync #(
    .WIDTH(3 * WIDTH)
  ) u_pin_input_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({pad_in_smbus_i, pad_in_ttl_i, pad_in_schmitt_i}),
    .sync_o(pad_sync)
  );

  assign sync_schmitt = pad_sync[WIDTH-1:0];
  assign sync_ttl = pad_sync[2*WIDTH-1:WIDTH];
  assign sync_smbus = pad_sync[3*WIDTH-1:2*WIDTH];

  always_comb
  begin
    threshold_pick = (input_threshold & sync_schmitt) | (~input_threshold & sync_ttl);
    threshold_pick = (two_wire_level & sync_smbus) | (~two_wire_level & threshold_pick);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_value <= '0;
      pin_value_prev <= '0;
    end
    else
    begin
      pin_value <= threshold_pick & ~analog_select & IMPL_MASK;
      pin_value_prev <= pin_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive

  logic [WIDTH-1:0] drive_source;
  logic [WIDTH-1:0] drive_en;

  always_comb
  begin
    drive_source = (routed_out_sel_i & routed_out_data_i) | (~routed_out_sel_i & output_latch);
    drive_en = ~direction & ~config_func_en_i & ~analog_out_en_i & IMPL_MASK;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pad_out_o <= '0;
      pad_oe_n_o <= '1;
    end
    else
    begin
      pad_out_o <= drive_source & ~open_drain & IMPL_MASK;
      pad_oe_n_o <= ~(drive_en & ~(open_drain & drive_source));
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pad_pullup_o <= '0;
      pad_slew_limit_o <= `GPIO_SLEW_RESET & IMPL_MASK;
    end
    else
    begin
      pad_pullup_o <= pullup_enable & ~drive_en;
      pad_slew_limit_o <= slew_limit & ~two_wire_slew;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read values and events

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      edge_event_o <= '0;
      routed_in_o <= '0;
    end
    else
    begin
      edge_event_o <= ((pin_value & ~pin_value_prev & edge_rise_en)
        | (~pin_value & pin_value_prev & edge_fall_en)) & IMPL_MASK;
      routed_in_o <= pin_value;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_level_o <= '0;
      output_latch_o <= `GPIO_LATCH_RESET & IMPL_MASK;
    end
    else
    begin
      pin_level_o <= pin_value;
      output_latch_o <= output_latch;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      direction_o <= `GPIO_DIRECTION_RESET & IMPL_MASK;
      analog_select_o <= `GPIO_ANALOG_RESET & IMPL_MASK;
      pullup_enable_o <= `GPIO_PULLUP_RESET & IMPL_MASK;
      input_threshold_o <= `GPIO_THRESHOLD_RESET & IMPL_MASK;
      slew_limit_o <= `GPIO_SLEW_RESET & IMPL_MASK;
      open_drain_o <= `GPIO_OPEN_DRAIN_RESET & IMPL_MASK;
      edge_rise_en_o <= '0;
      edge_fall_en_o <= '0;
      two_wire_slew_o <= '0;
      two_wire_pullup_o <= '0;
      two_wire_level_o <= '0;
    end
    else
    begin
      direction_o <= direction;
      analog_select_o <= analog_select;
      pullup_enable_o <= pullup_enable;
      input_threshold_o <= input_threshold;
      slew_limit_o <= slew_limit;
      open_drain_o <= open_drain;
      edge_rise_en_o <= edge_rise_en;
      edge_fall_en_o <= edge_fall_en;
      two_wire_slew_o <= two_wire_slew;
      two_wire_pullup_o <= two_wire_pullup;
      two_wire_level_o <= two_wire_level;
    end
  end

endmodule : general_purpose_io_port

// ### tb/gpio_port_asserts.sv
// Port-level assertions for the general purpose port
module gpio_port_asserts
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = 8'hf0,
  parameter logic [WIDTH-1:0] TWO_WIRE_MASK = 8'h50
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire reg_sel_type wr_sel_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [WIDTH-1:0] wr_bitmask_i,
  input wire logic [WIDTH-1:0] config_func_en_i,
  input wire logic [WIDTH-1:0] analog_out_en_i,
  input wire logic [WIDTH-1:0] pin_level_o,
  input wire logic [WIDTH-1:0] output_latch_o,
  input wire logic [WIDTH-1:0] direction_o,
  input wire logic [WIDTH-1:0] analog_select_o,
  input wire logic [WIDTH-1:0] pullup_enable_o,
  input wire logic [WIDTH-1:0] slew_limit_o,
  input wire logic [WIDTH-1:0] open_drain_o,
  input wire logic [WIDTH-1:0] two_wire_slew_o,
  input wire logic [WIDTH-1:0] routed_in_o,
  input wire logic [WIDTH-1:0] edge_event_o,
  input wire logic [WIDTH-1:0] pad_out_o,
  input wire logic [WIDTH-1:0] pad_oe_n_o,
  input wire logic [WIDTH-1:0] pad_pullup_o,
  input wire logic [WIDTH-1:0] pad_slew_limit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_latch_wr;
    wr_en_i && wr_sel_i == SEL_OUTPUT_LATCH && (&wr_bitmask_i);
  endsequence
  sequence s_dir_wr;
    wr_en_i && wr_sel_i == SEL_DIRECTION && (&wr_bitmask_i);
  endsequence
  property p_latch_wr;
    s_latch_wr |-> ##2 output_latch_o == ($past(wr_data_i, 2) & IMPL_MASK);
  endproperty
  a_latch_wr: assert property (p_latch_wr)
    else $error("latch readback differs from write");
  property p_dir_wr;
    s_dir_wr |-> ##2 direction_o == ($past(wr_data_i, 2) & IMPL_MASK);
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction readback differs from write");
  property p_unimpl;
    ((direction_o | analog_select_o | output_latch_o | pin_level_o | open_drain_o) & ~IMPL_MASK)
      == '0 && (two_wire_slew_o & ~TWO_WIRE_MASK) == '0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit reads one");
  property p_reset_vals;
    $rose(resetn_i) |-> analog_select_o == IMPL_MASK && direction_o == IMPL_MASK;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong value after reset");
  property p_dir_gate;
    (~pad_oe_n_o & direction_o) == '0;
  endproperty
  a_dir_gate: assert property (p_dir_gate)
    else $error("pad driven on an input pin");
  property p_analog_out;
    (~pad_oe_n_o & ($past(analog_out_en_i) | $past(config_func_en_i))) == '0;
  endproperty
  a_analog_out: assert property (p_analog_out)
    else $error("pad driven while a higher function owns it");
  property p_open_drain;
    (pad_out_o & open_drain_o) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pad drives high");
  property p_pullup;
    (pad_pullup_o & ~(pullup_enable_o & pad_oe_n_o)) == '0;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up on while driven or disabled");
  property p_slew;
    (pad_slew_limit_o & ~two_wire_slew_o) == (slew_limit_o & ~two_wire_slew_o);
  endproperty
  a_slew: assert property (p_slew)
    else $error("pad slew differs from slew control");
  property p_analog_in;
    (pin_level_o & analog_select_o & $past(analog_select_o) & $past(analog_select_o, 2)) == '0
      && routed_in_o == pin_level_o;
  endproperty
  a_analog_in: assert property (p_analog_in)
    else $error("analog pin reads one");
  property p_event;
    (edge_event_o & ~(pin_level_o ^ $past(pin_level_o))) == '0;
  endproperty
  a_event: assert property (p_event)
    else $error("edge event without a pin change");
endmodule : gpio_port_asserts

bind general_purpose_io_port gpio_port_asserts #(.WIDTH(WIDTH), .IMPL_MASK(IMPL_MASK),
  .TWO_WIRE_MASK(TWO_WIRE_MASK)) u_asserts (.clk_i(clk_i), .resetn_i(resetn_i),
  .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .wr_bitmask_i(wr_bitmask_i),
  .config_func_en_i(config_func_en_i), .analog_out_en_i(analog_out_en_i),
  .pin_level_o(pin_level_o), .output_latch_o(output_latch_o), .direction_o(direction_o),
  .analog_select_o(analog_select_o), .pullup_enable_o(pullup_enable_o),
  .slew_limit_o(slew_limit_o), .open_drain_o(open_drain_o), .two_wire_slew_o(two_wire_slew_o),
  .routed_in_o(routed_in_o), .edge_event_o(edge_event_o), .pad_out_o(pad_out_o),
  .pad_oe_n_o(pad_oe_n_o), .pad_pullup_o(pad_pullup_o), .pad_slew_limit_o(pad_slew_limit_o));

// ### tb/pad_model.sv
// Pin-side model: outside drivers, pull-ups and pad comparators
module pad_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_n_i,
  input wire logic [7:0] pad_pullup_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] mid_i,
  output logic [7:0] schmitt_o,
  output logic [7:0] ttl_o,
  output logic [7:0] smbus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] level;
  logic [7:0] last = 8'h00;
  logic [7:0] between;
  // Floating pins wander every cycle
  always @(posedge clk_i)
  begin
    last <= level;
  end
  // released pins follow outside driver or pull-up
  assign level = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_en_i & ext_val_i)
    | (pad_oe_n_i & ~ext_en_i & (pad_pullup_i | ~last));
  // mid voltage passes only low thresholds
  assign between = pad_oe_n_i & ext_en_i & mid_i;
  assign schmitt_o = level & ~between;
  assign ttl_o = level | between;
  assign smbus_o = level | between;
endmodule : pad_model

// ### tb/tb.sv
// Self-checking bench for the general purpose port
`include "gpio_port_regs.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {reg_sel_type sel; logic [7:0] exp;} row_type;
  logic clk_i, resetn_i, wr_en_i;
  reg_sel_type wr_sel_i;
  logic [7:0] wr_data_i, wr_bitmask_i, sch, ttl, smb, cfg, aout, rsel, rdata;
  logic [7:0] pin, lat, dir, ana, pu, thr, slw, od, rise, fall, tws, twp, twl;
  logic [7:0] rin, ev, pout, poe_n, ppu, pslew, ext_en, ext_val, mid, ev_or;
  logic [7:0] rbk [13];
  int mismatches, n_compared, cycles, ev_cnt;
  row_type rows [12] = '{'{SEL_OUTPUT_LATCH, 8'hf0}, '{SEL_DIRECTION, 8'hf0},
    '{SEL_ANALOG, 8'hf0}, '{SEL_PULLUP, 8'hf0}, '{SEL_THRESHOLD, 8'hf0}, '{SEL_SLEW, 8'hf0},
    '{SEL_OPEN_DRAIN, 8'hf0}, '{SEL_EDGE_RISE, 8'hf0}, '{SEL_EDGE_FALL, 8'hf0},
    '{SEL_TWO_WIRE_SLEW, 8'h50}, '{SEL_TWO_WIRE_PULLUP, 8'h50}, '{SEL_TWO_WIRE_LEVEL, 8'h50}};
  assign rbk = '{pin, lat, dir, ana, pu, thr, slw, od, rise, fall, tws, twp, twl};
  ////////////////////////////////////////////////////////////////////////////
  general_purpose_io_port uut (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i),
    .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .wr_bitmask_i(wr_bitmask_i),
    .pad_in_schmitt_i(sch), .pad_in_ttl_i(ttl), .pad_in_smbus_i(smb), .config_func_en_i(cfg),
    .analog_out_en_i(aout), .routed_out_sel_i(rsel), .routed_out_data_i(rdata),
    .pin_level_o(pin), .output_latch_o(lat), .direction_o(dir), .analog_select_o(ana),
    .pullup_enable_o(pu), .input_threshold_o(thr), .slew_limit_o(slw), .open_drain_o(od),
    .edge_rise_en_o(rise), .edge_fall_en_o(fall), .two_wire_slew_o(tws),
    .two_wire_pullup_o(twp), .two_wire_level_o(twl), .routed_in_o(rin), .edge_event_o(ev),
    .pad_out_o(pout), .pad_oe_n_o(poe_n), .pad_pullup_o(ppu), .pad_slew_limit_o(pslew));
  pad_model u_pads (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_n_i(poe_n), .pad_pullup_i(ppu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .mid_i(mid), .schmitt_o(sch), .ttl_o(ttl),
    .smbus_o(smb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic wr(input reg_sel_type s, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_sel_i <= s;
    wr_data_i <= d;
    wr_bitmask_i <= m;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : wr
  task automatic pins(input logic [7:0] e, input logic [7:0] v, input logic [7:0] md);
    @(posedge clk_i);
    ext_en <= e;
    ext_val <= v;
    mid <= md;
    ev_or = 8'h00;
    ev_cnt = 0;
    repeat (10)
    begin
      @(posedge clk_i);
      #1;
      ev_or |= ev;
      ev_cnt += $countones(ev);
    end
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    resetn_i = 1'b0;
    wr_sel_i = SEL_PIN_LEVEL;
    {wr_en_i, wr_data_i, wr_bitmask_i, cfg, aout, rsel, rdata, ext_en, ext_val, mid} = '0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].sel, 8'hff, 8'hff);
      `CHK("readback set", rows[i].exp, rbk[rows[i].sel]);
      wr(rows[i].sel, 8'h00, 8'hff);
      `CHK("readback clear", 8'h00, rbk[rows[i].sel]);
    end
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    `CHK("reset analog", `GPIO_IMPL_MASK, ana);
    `CHK("reset direction", `GPIO_IMPL_MASK, dir);
    `CHK("reset pad enable", 8'hff, poe_n);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    wr(SEL_ANALOG, 8'h00, 8'hff);
    wr(SEL_DIRECTION, 8'h00, 8'hff);
    wr(SEL_OUTPUT_LATCH, 8'ha5, 8'hff);
    `CHK("latch", 8'ha0, lat);
    `CHK("pad enable", 8'h0f, poe_n);
    `CHK("pad out", 8'ha0, pout);
    wr(SEL_PULLUP, 8'hff, 8'hff);
    `CHK("pad pull-up driven", 8'h00, ppu);
    `CHK("pull-up readback", 8'hf0, pu);
    wr(SEL_SLEW, 8'h00, 8'hff);
    `CHK("pad slew", 8'h00, pslew);
    wr(SEL_DIRECTION, 8'hff, 8'hff);
    `CHK("pad pull-up", 8'hf0, ppu);
    pins(8'hff, 8'h30, 8'h00);
    `CHK("pin level", 8'h30, pin);
    `CHK("latch kept", 8'ha0, lat);
    wr(SEL_PIN_LEVEL, 8'h80, 8'h80);
    `CHK("pin write", 8'hb0, lat);
    wr(SEL_OUTPUT_LATCH, 8'h00, 8'h10);
    `CHK("latch write", 8'ha0, lat);
    // threshold switched for pin level and routed input
    pins(8'hff, 8'h30, 8'h10);
    `CHK("schmitt level", 8'h20, pin);
    wr(SEL_THRESHOLD, 8'h00, 8'hff);
    pins(8'hff, 8'h30, 8'h10);
    `CHK("ttl level", 8'h30, rin);
    wr(SEL_ANALOG, 8'hff, 8'hff);
    pins(8'hff, 8'h30, 8'h10);
    `CHK("analog level", 8'h00, pin);
    `CHK("analog routed", 8'h00, rin);
    wr(SEL_DIRECTION, 8'h00, 8'hff);
    `CHK("analog drive", 8'h0f, poe_n);
    wr(SEL_OPEN_DRAIN, 8'hff, 8'hff);
    `CHK("open drain enable", 8'haf, poe_n);
    `CHK("open drain out", 8'h00, pout);
    wr(SEL_OPEN_DRAIN, 8'h00, 8'hff);
    @(posedge clk_i);
    aout <= 8'h10;
    cfg <= 8'h20;
    rsel <= 8'h40;
    rdata <= 8'h40;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("priority enable", 8'h3f, poe_n);
    `CHK("routed out", 8'hc0, pout & 8'hc0);
    @(posedge clk_i);
    {aout, cfg, rsel, rdata} <= '0;
    wr(SEL_ANALOG, 8'h00, 8'hff);
    wr(SEL_DIRECTION, 8'hff, 8'hff);
    wr(SEL_THRESHOLD, 8'hff, 8'hff);
    wr(SEL_EDGE_RISE, 8'h10, 8'hff);
    wr(SEL_EDGE_FALL, 8'h20, 8'hff);
    pins(8'hff, 8'h00, 8'h00);
    pins(8'hff, 8'h30, 8'h00);
    `CHK("rise events", 8'h10, ev_or);
    `CHK("rise count", 32'd1, ev_cnt);
    pins(8'hff, 8'h00, 8'h00);
    `CHK("fall events", 8'h20, ev_or);
    `CHK("fall count", 32'd1, ev_cnt);
    // open drain on the two-wire pins
    wr(SEL_OPEN_DRAIN, 8'h50, 8'hff);
    wr(SEL_TWO_WIRE_LEVEL, 8'hff, 8'hff);
    `CHK("two-wire level", 8'h50, twl);
    pins(8'hff, 8'h30, 8'h30);
    `CHK("smbus level", 8'h10, rin);
    wr(SEL_SLEW, 8'hff, 8'hff);
    wr(SEL_TWO_WIRE_SLEW, 8'h10, 8'hff);
    `CHK("two-wire slew", 8'he0, pslew);
    finish_test();
  end
endmodule : tb
